// ==== verilog/ttr_pkg.sv ====
// constants and register-space layout for the i2c target register port
// Function
// - device acknowledges its own address for both reads and writes
// - device acknowledges sub-address and loads it into the pointer
// - device stores and acknowledges each data byte; more bytes may follow
// - read starts at 00h or one past the last register read
// - after a pointer write, read starts at that sub-address
// - device waits for ack or nack after each byte it sends
// - pointer advances after each read byte, before its ack bit; on ack the next byte is sent
// - address plus one sub-address byte then stop only sets the pointer
// - reads continue through consecutive registers until controller stops
// - readable fields return their value; writable fields take written value
// - set-type fields: one sets, zero leaves unchanged
// - clear-type fields: one clears, zero leaves unchanged
// - hardware-updated fields change without writes; reads show live value
// - no-access fields read as zero and ignore writes
package ttr_pkg;
  localparam int          NREG      = 4;
  localparam int          BYTE_W    = 8;
  localparam int          ADDR_W    = 7;
  localparam logic [2:0]  LAST_BIT  = 3'h7;
  localparam logic [7:0]  PTR_RST   = 8'h00;
  localparam logic [7:0]  PTR_STEP  = 8'h01;
  localparam logic [7:0]  BYTE_ZERO = 8'h00;

  // per-register reset values and access masks, index is the sub-address
  localparam logic [7:0] RST_VAL  [NREG] = '{8'h01, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] RD_MASK  [NREG] = '{8'hFF, 8'hFF, 8'hFF, 8'h0F};
  localparam logic [7:0] WR_MASK  [NREG] = '{8'hFF, 8'hFF, 8'h00, 8'h00};
  localparam logic [7:0] SET_MASK [NREG] = '{8'h00, 8'h00, 8'hFF, 8'h00};
  localparam logic [7:0] CLR_MASK [NREG] = '{8'h00, 8'h00, 8'h00, 8'h0F};
  localparam logic [7:0] UPD_MASK [NREG] = '{8'h00, 8'hF0, 8'h00, 8'h0F};

  typedef enum logic [2:0] {
    TTR_IDLE  = 3'h0,
    TTR_ADDR  = 3'h1,
    TTR_ACK   = 3'h3,
    TTR_SUB   = 3'h2,
    TTR_WDATA = 3'h6,
    TTR_RDATA = 3'h7,
    TTR_RACK  = 3'h5
  } ttr_state_e;
endpackage

// ==== verilog/ttr_reg_byte.sv ====
// one byte of the register space with per-bit access types
`timescale 1ns/100ps
module ttr_reg_byte #(
  parameter logic [7:0] RST = 8'h00,
  parameter logic [7:0] WRM = 8'h00,
  parameter logic [7:0] SETM = 8'h00,
  parameter logic [7:0] CLRM = 8'h00,
  parameter logic [7:0] UPDM = 8'h00
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // software write strobe
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  // hardware update
  input  wire logic [7:0] hw_en,
  input  wire logic [7:0] hw_val,
  // contents
  output logic      [7:0] q
);
  logic [7:0] q_d;

  always_comb
  begin
    q_d = q;
    if (wr_en)
    begin
      q_d = (q_d & ~WRM) | (wr_data & WRM);
      q_d = q_d | (wr_data & SETM);
      q_d = q_d & ~(wr_data & CLRM);
    end
    // hardware update wins over a same-cycle software clear
    q_d = (q_d & ~(hw_en & UPDM)) | (hw_val & hw_en & UPDM);
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      q <= RST;
    else
      q <= q_d;
  end

  localparam logic [7:0] FIXM = ~(WRM | SETM | CLRM | UPDM);

  property p_na_hold;
    @(posedge clk) disable iff (sys_rst)
    1'b1 |=> ((q & FIXM) == ($past(q) & FIXM));
  endproperty
  a_na_hold: assert property (p_na_hold) else $error("no-access bit moved");
endmodule

// ==== verilog/ttr_i2c_target.sv ====
// i2c target: sub-address pointer, byte writes and reads of register space
`timescale 1ns/100ps
module ttr_i2c_target (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                sys_rst,
  // own 7-bit target address, from address-select straps
  input  wire logic [6:0]          dev_addr,
  // i2c bus, open drain data
  input  wire logic                scl_i,
  input  wire logic                sda_i,
  output logic                     sda_o,
  output logic                     sda_oe,
  // hardware update of register fields
  input  wire logic [3:0][7:0]     hw_en,
  input  wire logic [3:0][7:0]     hw_val,
  // register contents to the device core
  output logic      [3:0][7:0]     reg_q
);
  ttr_pkg::ttr_state_e st_q;
  ttr_pkg::ttr_state_e nxt_q;
  logic       scl_q;
  logic       sda_q;
  logic [2:0] cnt_q;
  logic [7:0] shift_q;
  logic [7:0] ptr_q;
  logic [7:0] wr_addr_q;
  logic [7:0] wr_data_q;
  logic       wr_stb_q;
  logic       rw_q;
  logic       ack_drv_q;
  logic       rack_ok_q;
  logic       sda_oe_q;
  logic       sda_o_q;

  wire scl_rise = scl_i & ~scl_q;
  wire scl_fall = ~scl_i & scl_q;
  wire bus_start = scl_i & scl_q & sda_q & ~sda_i;
  wire bus_stop = scl_i & scl_q & ~sda_q & sda_i;
  wire last_bit = (cnt_q == ttr_pkg::LAST_BIT);
  wire [7:0] in_byte = {shift_q[6:0], sda_i};
  // readable view of one register; out-of-range and no-access bits read 0
  function automatic logic [7:0] rd_sel(input logic [7:0] idx,
                                        input logic [3:0][7:0] r);
    logic [7:0] v;
    v = ttr_pkg::BYTE_ZERO;
    for (int i = 0; i < ttr_pkg::NREG; i++)
      if (idx == 8'(i))
        v = r[i] & ttr_pkg::RD_MASK[i];
    return v;
  endfunction
  wire [7:0] rd_byte = rd_sel(ptr_q, reg_q);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
    sda_o_q <= 1'b0;
  end

  // protocol sequencer
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_q      <= ttr_pkg::TTR_IDLE;
      nxt_q     <= ttr_pkg::TTR_IDLE;
      cnt_q     <= 3'h0;
      shift_q   <= ttr_pkg::BYTE_ZERO;
      rw_q      <= 1'b0;
      ack_drv_q <= 1'b0;
      rack_ok_q <= 1'b0;
      sda_oe_q  <= 1'b0;
    end
    else if (bus_stop)
    begin
      st_q      <= ttr_pkg::TTR_IDLE;
      sda_oe_q  <= 1'b0;
      ack_drv_q <= 1'b0;
    end
    else if (bus_start)
    begin
      st_q      <= ttr_pkg::TTR_ADDR;
      cnt_q     <= 3'h0;
      ack_drv_q <= 1'b0;
      sda_oe_q  <= 1'b0;
    end
    else
    begin
      case (st_q)
        ttr_pkg::TTR_ADDR, ttr_pkg::TTR_SUB, ttr_pkg::TTR_WDATA:
        begin
          if (scl_rise)
          begin
            shift_q <= in_byte;
            cnt_q   <= cnt_q + 3'h1;
            if (last_bit)
            begin
              st_q <= ttr_pkg::TTR_ACK;
              if (st_q == ttr_pkg::TTR_ADDR)
              begin
                // upper seven bits address, lsb direction
                rw_q  <= sda_i;
                nxt_q <= sda_i ? ttr_pkg::TTR_RDATA : ttr_pkg::TTR_SUB;
                if (in_byte[7:1] != dev_addr)
                  st_q <= ttr_pkg::TTR_IDLE;
              end
              else
                nxt_q <= ttr_pkg::TTR_WDATA;
            end
          end
        end
        ttr_pkg::TTR_ACK:
        begin
          if (scl_fall)
          begin
            if (!ack_drv_q)
            begin
              ack_drv_q <= 1'b1;
              sda_oe_q  <= 1'b1;
            end
            else
            begin
              ack_drv_q <= 1'b0;
              st_q      <= nxt_q;
              cnt_q     <= 3'h0;
              if (nxt_q == ttr_pkg::TTR_RDATA)
              begin
                sda_oe_q <= ~rd_byte[7];
                shift_q  <= {rd_byte[6:0], 1'b0};
              end
              else
                sda_oe_q <= 1'b0;
            end
          end
        end
        ttr_pkg::TTR_RDATA:
        begin
          if (scl_rise)
          begin
            cnt_q <= cnt_q + 3'h1;
            if (last_bit)
            begin
              st_q      <= ttr_pkg::TTR_RACK;
              rack_ok_q <= 1'b0;
            end
          end
          else if (scl_fall)
          begin
            sda_oe_q <= ~shift_q[7];
            shift_q  <= {shift_q[6:0], 1'b0};
          end
        end
        ttr_pkg::TTR_RACK:
        begin
          if (scl_fall && !rack_ok_q)
            sda_oe_q <= 1'b0;
          else if (scl_fall)
          begin
            st_q     <= ttr_pkg::TTR_RDATA;
            cnt_q    <= 3'h0;
            sda_oe_q <= ~rd_byte[7];
            shift_q  <= {rd_byte[6:0], 1'b0};
          end
          if (scl_rise)
          begin
            if (sda_i)
              st_q <= ttr_pkg::TTR_IDLE;
            else
              rack_ok_q <= 1'b1;
          end
        end
        default:
          sda_oe_q <= 1'b0;
      endcase
    end
  end

  // pointer kept across transfers: a lone pointer write sets read start
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ptr_q <= ttr_pkg::PTR_RST;
    else if (!bus_start && !bus_stop && scl_rise && last_bit)
    begin
      if (st_q == ttr_pkg::TTR_SUB)
        ptr_q <= in_byte;
      else if (st_q == ttr_pkg::TTR_WDATA)
        ptr_q <= ptr_q + ttr_pkg::PTR_STEP;
      else if (st_q == ttr_pkg::TTR_RDATA)
        ptr_q <= ptr_q + ttr_pkg::PTR_STEP;
    end
  end

  // write strobe to the register space
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wr_stb_q  <= 1'b0;
      wr_addr_q <= ttr_pkg::PTR_RST;
      wr_data_q <= ttr_pkg::BYTE_ZERO;
    end
    else
    begin
      wr_stb_q <= !bus_start && !bus_stop && scl_rise && last_bit
                  && (st_q == ttr_pkg::TTR_WDATA);
      wr_addr_q <= ptr_q;
      wr_data_q <= in_byte;
    end
  end

  assign sda_oe = sda_oe_q;
  assign sda_o  = sda_o_q;

  for (genvar g = 0; g < ttr_pkg::NREG; g++)
  begin : g_reg
    ttr_reg_byte #(
      .RST  (ttr_pkg::RST_VAL[g]),
      .WRM  (ttr_pkg::WR_MASK[g]),
      .SETM (ttr_pkg::SET_MASK[g]),
      .CLRM (ttr_pkg::CLR_MASK[g]),
      .UPDM (ttr_pkg::UPD_MASK[g])
    ) u_byte (
      .clk     (clk),
      .sys_rst (sys_rst),
      .wr_en   (wr_stb_q && (wr_addr_q == 8'(g))),
      .wr_data (wr_data_q),
      .hw_en   (hw_en[g]),
      .hw_val  (hw_val[g]),
      .q       (reg_q[g])
    );
  end

  // checks
  wire quiet = !bus_start && !bus_stop;
  property p_addr_ack;
    @(posedge clk) disable iff (sys_rst)
    (st_q == ttr_pkg::TTR_ADDR && quiet && scl_rise && last_bit
     && in_byte[7:1] == dev_addr) |=> (st_q == ttr_pkg::TTR_ACK);
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address not acked");
  property p_sub_ptr;
    @(posedge clk) disable iff (sys_rst)
    (st_q == ttr_pkg::TTR_SUB && quiet && scl_rise && last_bit)
      |=> (ptr_q == $past(in_byte));
  endproperty
  a_sub_ptr: assert property (p_sub_ptr) else $error("pointer not loaded");
  property p_wr_stb;
    @(posedge clk) disable iff (sys_rst)
    (st_q == ttr_pkg::TTR_WDATA && quiet && scl_rise && last_bit)
      |=> (wr_stb_q && wr_data_q == $past(in_byte));
  endproperty
  a_wr_stb: assert property (p_wr_stb) else $error("write byte lost");
  property p_wr_inc;
    @(posedge clk) disable iff (sys_rst)
    wr_stb_q |-> (ptr_q == wr_addr_q + ttr_pkg::PTR_STEP);
  endproperty
  a_wr_inc: assert property (p_wr_inc) else $error("write pointer stuck");
  property p_rd_inc;
    @(posedge clk) disable iff (sys_rst)
    (st_q == ttr_pkg::TTR_RDATA && quiet && scl_rise && last_bit)
      |=> (ptr_q == $past(ptr_q) + ttr_pkg::PTR_STEP);
  endproperty
  a_rd_inc: assert property (p_rd_inc) else $error("read pointer stuck");
  property p_nack_rel;
    @(posedge clk) disable iff (sys_rst)
    (st_q == ttr_pkg::TTR_RACK && quiet && scl_rise && sda_i)
      |=> (st_q == ttr_pkg::TTR_IDLE && !sda_oe_q)[*2];
  endproperty
  a_nack_rel: assert property (p_nack_rel) else $error("nack not released");
  sequence s_ack_end;
    st_q == ttr_pkg::TTR_ACK && ack_drv_q && quiet && scl_fall;
  endsequence
  property p_rd_first;
    @(posedge clk) disable iff (sys_rst)
    (s_ack_end and rw_q) |=> (st_q == ttr_pkg::TTR_RDATA
                              && sda_oe_q == ~$past(rd_byte[7]));
  endproperty
  a_rd_first: assert property (p_rd_first) else $error("bad first bit");
  property p_ack_low;
    @(posedge clk) disable iff (sys_rst)
    ack_drv_q |-> sda_oe_q;
  endproperty
  a_ack_low: assert property (p_ack_low) else $error("ack not driven");
  property p_stop_idle;
    @(posedge clk) disable iff (sys_rst)
    bus_stop |=> (st_q == ttr_pkg::TTR_IDLE && !sda_oe_q);
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop ignored");
endmodule

// ==== dv/ttr_ctl_model.sv ====
// behavioural i2c bus controller driving the target's scl and sda
`timescale 1ns/100ps
module ttr_ctl_model (
  // clock
  input  wire logic clk,
  // bus lines, sda resolved outside with a pull-up
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda
);
  // quarter of an scl period; each scl phase lasts two of these
  localparam int QTR = 3;

  initial
  begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // data changes only while scl is low, sampled mid high phase
  task automatic put_bit(input logic b, output logic seen);
    sda_drv = b;
    tick(QTR);
    scl = 1'b1;
    tick(QTR);
    seen = sda;
    tick(QTR);
    scl = 1'b0;
    tick(QTR);
  endtask

  task automatic start();
    sda_drv = 1'b1;
    tick(QTR);
    scl = 1'b1;
    tick(QTR);
    sda_drv = 1'b0;
    tick(QTR);
    scl = 1'b0;
    tick(QTR);
  endtask

  task automatic stop();
    sda_drv = 1'b0;
    tick(QTR);
    scl = 1'b1;
    tick(QTR);
    sda_drv = 1'b1;
    tick(2 * QTR);
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      put_bit(d[i], s);
    put_bit(1'b1, s);
    ack = ~s;
  endtask

  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      put_bit(1'b1, d[i]);
    put_bit(~ack, s);
  endtask
endmodule

// ==== dv/tb_top.sv ====
// self-checking bench for the i2c target register port
`timescale 1ns/100ps
module tb_top;
  logic             clk;
  logic             sys_rst;
  logic [6:0]       dev_addr;
  logic [3:0][7:0]  hw_en;
  logic [3:0][7:0]  hw_val;
  logic [3:0][7:0]  reg_q;
  logic             scl;
  logic             sda_drv;
  logic             sda_o;
  logic             sda_oe;
  logic             sda;
  logic             ack;
  logic             s;
  logic [7:0]       rd;
  int               n_mismatch;
  int               comparisons;

  // open drain wire with pull-up
  assign sda = sda_drv & ~sda_oe;

  ttr_i2c_target u_dut (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .dev_addr (dev_addr),
    .scl_i    (scl),
    .sda_i    (sda),
    .sda_o    (sda_o),
    .sda_oe   (sda_oe),
    .hw_en    (hw_en),
    .hw_val   (hw_val),
    .reg_q    (reg_q)
  );

  ttr_ctl_model u_ctl (
    .clk     (clk),
    .scl     (scl),
    .sda_drv (sda_drv),
    .sda     (sda)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (n_mismatch == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic head(input logic rd_n);
    u_ctl.start();
    u_ctl.wbyte({dev_addr, rd_n}, ack);
    chk("address ack", {7'h00, ack}, 8'h01);
  endtask

  // sub-address then n data bytes, each acked
  task automatic wr(input logic [7:0] sub, input logic [7:0] d [4],
                    input int n);
    head(1'b0);
    u_ctl.wbyte(sub, ack);
    chk("sub ack", {7'h00, ack}, 8'h01);
    for (int i = 0; i < n; i++)
    begin
      u_ctl.wbyte(d[i], ack);
      chk("data ack", {7'h00, ack}, 8'h01);
    end
    u_ctl.stop();
  endtask

  task automatic t_reset();
    for (int i = 0; i < 4; i++)
      chk("reset value", reg_q[i], ttr_pkg::RST_VAL[i]);
    chk("sda drive level", {7'h00, sda_o}, 8'h00);
  endtask

  task automatic t_wrong_addr();
    u_ctl.start();
    u_ctl.wbyte({dev_addr ^ 7'h01, 1'b0}, ack);
    chk("foreign address ack", {7'h00, ack}, 8'h00);
    u_ctl.stop();
  endtask

  // burst over all four registers, pointer steps each byte
  task automatic t_write_burst();
    wr(8'h00, '{8'hA5, 8'h5A, 8'h81, 8'hF2}, 4);
    chk("reg0 rw", reg_q[0], 8'hA5);
    chk("reg1 rw", reg_q[1], 8'h5A);
    chk("reg2 set", reg_q[2], 8'h81);
    chk("reg3 noaccess", reg_q[3], 8'h00);
  endtask

  task automatic t_hw_clear();
    hw_en[3]  = 8'h0F;
    hw_val[3] = 8'h0B;
    hw_en[1]  = 8'hF0;
    hw_val[1] = 8'h30;
    repeat (2) @(negedge clk);
    hw_en[3]  = 8'h00;
    hw_en[1]  = 8'h00;
    repeat (2) @(negedge clk);
    chk("reg3 update", reg_q[3], 8'h0B);
    chk("reg1 update", reg_q[1], 8'h3A);
    wr(8'h02, '{8'h00, 8'h03, 8'h00, 8'h00}, 2);
    chk("reg2 zero keeps", reg_q[2], 8'h81);
    chk("reg3 clear", reg_q[3], 8'h08);
  endtask

  task automatic t_read_burst();
    wr(8'h01, '{8'h00, 8'h00, 8'h00, 8'h00}, 0);
    head(1'b1);
    u_ctl.rbyte(1'b1, rd);
    chk("read first", rd, 8'h3A);
    u_ctl.rbyte(1'b1, rd);
    chk("read second", rd, 8'h81);
    u_ctl.rbyte(1'b0, rd);
    chk("read third", rd, 8'h08);
    u_ctl.put_bit(1'b1, s);
    chk("released after nack", {7'h00, s}, 8'h01);
    u_ctl.stop();
  endtask

  task automatic t_read_resume();
    wr(8'h00, '{8'h00, 8'h00, 8'h00, 8'h00}, 0);
    head(1'b1);
    u_ctl.rbyte(1'b0, rd);
    chk("read at zero", rd, 8'hA5);
    u_ctl.stop();
    head(1'b1);
    u_ctl.rbyte(1'b0, rd);
    chk("read resumes", rd, 8'h3A);
    u_ctl.stop();
  endtask

  // mid-run reset, then a read with no pointer write starts at 00h
  task automatic t_reset_read();
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    head(1'b1);
    u_ctl.rbyte(1'b0, rd);
    chk("read after reset", rd, 8'h01);
    u_ctl.stop();
  endtask

  initial
  begin
    n_mismatch  = 0;
    comparisons = 0;
    sys_rst     = 1'b1;
    dev_addr    = 7'h2C;
    hw_en       = '0;
    hw_val      = '0;
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    t_reset();
    t_wrong_addr();
    t_write_burst();
    t_hw_clear();
    t_read_burst();
    t_read_resume();
    t_reset_read();
    finish_test();
  end

  // whole run is a few thousand cycles; this is about ten times that
  initial
  begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end
endmodule
